/* mpcr_defines.svh */
// Constants for the program change router: identifier, sizes, codes, limits, reset values.
// Assumes every file that needs it includes it; the guard stops repeats.
`ifndef MPCR_DEFINES_SVH
`define MPCR_DEFINES_SVH
// Arbitrary neutral manufacturer identifier for system exclusive
`define MPCR_SYSEX_ID 24'h5A5A5A
`define MPCR_SRC_N 3
`define MPCR_EXT_N 12
`define MPCR_MAP_N 128
`define MPCR_FIFO_W 8
`define MPCR_FIFO_D 16
`define MPCR_PC_NIBBLE 4'hC
`define MPCR_RT_FIRST 8'hF8
`define MPCR_MAP_LIMIT 9'h080
`define MPCR_EXT_FULL 7'h7F
`define MPCR_EXT_ZERO 7'h00
`define MPCR_STAT_RST 8'h00
`endif

/* mpcr_pkg.sv */
// Types shared by the router: modes, message kinds and sequencer states.
// Assumes mpcr_defines.svh sits in the same folder.
`include "mpcr_defines.svh"
package mpcr_pkg;
   typedef enum logic [1:0] {
      MPCR_LIVE_NONE = 2'b00,
      MPCR_LIVE_ALL = 2'b01,
      MPCR_LIVE_TUNER = 2'b10,
      MPCR_LIVE_TEMPO = 2'b11
   } mpcr_live_type;
   typedef enum logic [1:0] {
      MPCR_KIND_OTHER = 2'b00,
      MPCR_KIND_TUNER = 2'b01,
      MPCR_KIND_TEMPO = 2'b10
   } mpcr_kind_type;
   typedef enum logic [1:0] {
      MPCR_PC_IDLE = 2'b00,
      MPCR_PC_LOOK = 2'b01,
      MPCR_PC_ISSUE = 2'b10
   } mpcr_pc_state_type;
endpackage

/* mpcr_router.sv */
// MIDI program change router with serial, foot controller and USB ports.
// Assumes byte streams on clk with valid/ready; fw_update is synchronous.
`timescale 1ns/1ps
`include "mpcr_defines.svh"

module mpcr_fifo #(
   parameter int W = `MPCR_FIFO_W,
   parameter int D = `MPCR_FIFO_D
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_ff [D];
   logic [W-1:0] nxt_mem [D];
   logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic push, pop;
   assign in_ready = (cnt_ff != D[AW:0]);
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rp_ff];
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      nxt_mem = mem_ff;
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      if (push) begin
         nxt_mem[wp_ff] = in_data;
         nxt_wp = wp_ff + 1'b1;
      end
      if (pop) begin
         nxt_rp = rp_ff + 1'b1;
      end
      nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end
   always_ff @(posedge clk) begin
      mem_ff <= nxt_mem;
      if (!rst_b) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule // mpcr_fifo

// Overview of operation
// - Act on program changes only on the set channel, or on all with any_channel.
// - Echo merge copies serial input to serial output, off during update.
// - Program change enable decides whether program changes act or vanish.
// - Without remapping the loaded preset equals the offset program number.
// - Custom remapping translates 0-127 through a table to preset and scene.
// - Discard off keeps scene edits until a preset load or reload.
// - Discard on drops unsaved edits whenever the scene switches.
// - A fixed read-only manufacturer identifier is exposed.
// - Display numbering base only shifts shown numbers, never selection.
// - Suppress off reloads the current preset and drops unsaved edits.
// - Suppress on drops a program change naming the current preset and scene; a differing remapped scene still loads.
// - Live status select passes none, all, tuner or tempo messages.
// - Bridge off processes every input locally with no forwarding.
// - Bridge on relays serial and foot controller input to USB.
// - Bridge on sends USB input to serial and foot controller outputs.
// - Bridge and echo are independent; serial output merges four sources.
// - Bridge forwarding is forced off during a firmware update.
// - Add the bank value 0-255 to each program number first.
// - Each of 12 controllers holds its 0 or 100 percent default until data.
module mpcr_router (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] rx_channel,
   input wire logic any_channel,
   input wire logic input_echo_merge,
   input wire logic fw_update,
   input wire logic pc_enable,
   input wire logic pc_remap_select,
   input wire logic [7:0] pc_bank_add,
   input wire logic repeat_pc_suppress,
   input wire logic scene_edit_discard,
   input wire logic display_numbering_base,
   input wire mpcr_pkg::mpcr_live_type live_status_msg_select,
   input wire logic host_bridge_forwarding,
   input wire logic remap_wr_en,
   input wire logic [6:0] remap_wr_from,
   input wire logic [8:0] remap_target_preset,
   input wire logic [2:0] remap_target_scene,
   input wire logic ser_in_valid,
   output logic ser_in_ready,
   input wire logic [7:0] ser_in_data,
   input wire logic fc_in_valid,
   output logic fc_in_ready,
   input wire logic [7:0] fc_in_data,
   input wire logic usb_in_valid,
   output logic usb_in_ready,
   input wire logic [7:0] usb_in_data,
   input wire logic int_valid,
   output logic int_ready,
   input wire logic [7:0] int_data,
   input wire mpcr_pkg::mpcr_kind_type int_kind,
   output logic ser_out_valid,
   input wire logic ser_out_ready,
   output logic [7:0] ser_out_data,
   output logic fc_out_valid,
   input wire logic fc_out_ready,
   output logic [7:0] fc_out_data,
   output logic usb_out_valid,
   input wire logic usb_out_ready,
   output logic [7:0] usb_out_data,
   output logic preset_load,
   output logic scene_load,
   output logic [8:0] load_preset,
   output logic [2:0] load_scene,
   output logic scene_edits_drop,
   input wire logic edit_made,
   output logic edits_pending,
   output logic [23:0] sysex_mfr_id,
   output logic [9:0] display_preset,
   input wire logic ext_wr_en,
   input wire logic [3:0] ext_wr_idx,
   input wire logic [6:0] ext_wr_val,
   input wire logic [11:0] ext_default_full,
   output logic [83:0] ext_value
);
   import mpcr_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   localparam int N = `MPCR_SRC_N;
   logic [N-1:0] vin, rdy, acc, need_u, need_f, need_c, ugnt, fgnt, fok;
   logic [8*N-1:0] din;
   logic [N-1:0] pend, clr;
   logic [7*N-1:0] pnum;
   logic echo_on, bridge_on, int_pass, fgi, blocked, f_ready, f_valid;
   logic [7:0] f_data;
   logic u_free, c_free;
   logic uv_ff, nxt_uv, cv_ff, nxt_cv;
   logic [7:0] ud_ff, nxt_ud, cd_ff, nxt_cd;

   assign vin = {usb_in_valid, fc_in_valid, ser_in_valid};
   assign din = {usb_in_data, fc_in_data, ser_in_data};
   assign ser_in_ready = rdy[0];
   assign fc_in_ready = rdy[1];
   assign usb_in_ready = rdy[2];
   assign acc = vin & rdy;
   assign sysex_mfr_id = `MPCR_SYSEX_ID;
   assign u_free = !uv_ff || usb_out_ready;
   assign c_free = !cv_ff || fc_out_ready;
   assign usb_out_valid = uv_ff;
   assign usb_out_data = ud_ff;
   assign fc_out_valid = cv_ff;
   assign fc_out_data = cd_ff;

   // Routing grants; a source is taken only when every target can take it
   always_comb begin
      echo_on = input_echo_merge && !fw_update;
      bridge_on = host_bridge_forwarding && !fw_update;
      need_u = {1'b0, bridge_on, bridge_on};
      need_c = {bridge_on, 2'b00};
      need_f = {bridge_on, echo_on, echo_on};
      ugnt = '0;
      ugnt[0] = vin[0] && need_u[0] && u_free;
      ugnt[1] = vin[1] && need_u[1] && u_free && !ugnt[0];
      case (live_status_msg_select)
         MPCR_LIVE_NONE: int_pass = (int_kind == MPCR_KIND_OTHER);
         MPCR_LIVE_TUNER: int_pass = (int_kind != MPCR_KIND_TEMPO);
         MPCR_LIVE_TEMPO: int_pass = (int_kind != MPCR_KIND_TUNER);
         default: int_pass = 1'b1;
      endcase
      fgi = int_valid && int_pass && f_ready;
      int_ready = int_pass ? f_ready : 1'b1;
      blocked = int_valid && int_pass;
      fgnt = '0;
      for (int i = 0; i < N; i++) begin
         fok[i] = (!need_u[i] || ugnt[i]) && (!need_c[i] || c_free);
         if (vin[i] && need_f[i] && fok[i]) begin
            fgnt[i] = f_ready && !blocked;
            blocked = 1'b1;
         end
         rdy[i] = fok[i] && (!need_f[i] || fgnt[i]);
      end
      f_valid = fgi || (|fgnt);
      if (fgi) begin
         f_data = int_data;
      end else if (fgnt[0]) begin
         f_data = din[7:0];
      end else if (fgnt[1]) begin
         f_data = din[15:8];
      end else begin
         f_data = din[23:16];
      end
   end

   always_comb begin
      nxt_uv = uv_ff && !usb_out_ready;
      nxt_ud = ud_ff;
      nxt_cv = cv_ff && !fc_out_ready;
      nxt_cd = cd_ff;
      if (acc[0] && need_u[0]) begin
         nxt_uv = 1'b1;
         nxt_ud = din[7:0];
      end else if (acc[1] && need_u[1]) begin
         nxt_uv = 1'b1;
         nxt_ud = din[15:8];
      end
      if (acc[2] && need_c[2]) begin
         nxt_cv = 1'b1;
         nxt_cd = din[23:16];
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         uv_ff <= 1'b0;
         ud_ff <= 8'h00;
         cv_ff <= 1'b0;
         cd_ff <= 8'h00;
      end else begin
         uv_ff <= nxt_uv;
         ud_ff <= nxt_ud;
         cv_ff <= nxt_cv;
         cd_ff <= nxt_cd;
      end
   end

   // Serial output merge; bytes interleave, so sources must not overlap
   // multi-byte messages if the far end needs them whole
   mpcr_fifo #(.W(`MPCR_FIFO_W), .D(`MPCR_FIFO_D)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(f_valid),
      .in_ready(f_ready),
      .in_data(f_data),
      .out_valid(ser_out_valid),
      .out_ready(ser_out_ready),
      .out_data(ser_out_data)
   );

   // Per-source parser with running status; serial, foot controller and USB sources are processed, internal is not
   genvar g;
   for (g = 0; g < N; g++) begin : g_parse
      logic [7:0] st_ff, nxt_st, b;
      logic pd_ff, nxt_pd, hit;
      logic [6:0] pn_ff, nxt_pn;
      always_comb begin
         b = din[8*g +: 8];
         nxt_st = st_ff;
         hit = acc[g] && !b[7] && (st_ff[7:4] == `MPCR_PC_NIBBLE)
            && (any_channel || st_ff[3:0] == rx_channel)
            && pc_enable;
         if (acc[g] && b[7] && b < `MPCR_RT_FIRST) begin
            nxt_st = b;
         end
         // A new event in the clearing cycle survives
         nxt_pd = hit || (pd_ff && !clr[g]);
         nxt_pn = hit ? b[6:0] : pn_ff;
      end
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            st_ff <= `MPCR_STAT_RST;
            pd_ff <= 1'b0;
            pn_ff <= 7'h00;
         end else begin
            st_ff <= nxt_st;
            pd_ff <= nxt_pd;
            pn_ff <= nxt_pn;
         end
      end
      assign pend[g] = pd_ff;
      assign pnum[7*g +: 7] = pn_ff;
   end

   // Remap table
   logic [8:0] mp_ff [`MPCR_MAP_N];
   logic [2:0] ms_ff [`MPCR_MAP_N];
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         for (int i = 0; i < `MPCR_MAP_N; i++) begin
            mp_ff[i] <= 9'(i);
            ms_ff[i] <= 3'h0;
         end
      end else if (remap_wr_en) begin
         mp_ff[remap_wr_from] <= remap_target_preset;
         ms_ff[remap_wr_from] <= remap_target_scene;
      end
   end

   // Program change sequencer
   mpcr_pc_state_type st_ff, nxt_st;
   logic [8:0] num_ff, nxt_num, tgt_ff, nxt_tgt, cur_ff, nxt_cur;
   logic [2:0] tsc_ff, nxt_tsc, csc_ff, nxt_csc;
   logic tsv_ff, nxt_tsv, ld_ff, nxt_ld, same, scene_diff;
   logic pl_ff, nxt_pl, sl_ff, nxt_sl, dr_ff, nxt_dr, ep_ff, nxt_ep;
   logic [6:0] sel_num;
   always_comb begin
      nxt_st = st_ff;
      nxt_num = num_ff;
      nxt_tgt = tgt_ff;
      nxt_tsc = tsc_ff;
      nxt_tsv = tsv_ff;
      nxt_cur = cur_ff;
      nxt_csc = csc_ff;
      nxt_ld = ld_ff;
      nxt_pl = 1'b0;
      nxt_sl = 1'b0;
      nxt_dr = 1'b0;
      clr = '0;
      same = ld_ff && (tgt_ff == cur_ff);
      scene_diff = tsv_ff && (tsc_ff != csc_ff);
      sel_num = pend[0] ? pnum[6:0] : (pend[1] ? pnum[13:7] : pnum[20:14]);
      case (st_ff)
         MPCR_PC_IDLE: begin
            if (|pend) begin
               clr = pend[0] ? 3'b001 : (pend[1] ? 3'b010 : 3'b100);
               nxt_num = {2'b00, sel_num} + {1'b0, pc_bank_add};
               nxt_st = MPCR_PC_LOOK;
            end
         end
         MPCR_PC_LOOK: begin
            if (pc_remap_select && num_ff < `MPCR_MAP_LIMIT) begin
               nxt_tgt = mp_ff[num_ff[6:0]];
               nxt_tsc = ms_ff[num_ff[6:0]];
               nxt_tsv = 1'b1;
            end else begin
               nxt_tgt = num_ff;
               nxt_tsv = 1'b0;
            end
            nxt_st = MPCR_PC_ISSUE;
         end
         MPCR_PC_ISSUE: begin
            nxt_st = MPCR_PC_IDLE;
            if (!(same && repeat_pc_suppress)) begin
               nxt_pl = 1'b1;
               nxt_sl = tsv_ff;
               nxt_cur = tgt_ff;
               nxt_csc = tsv_ff ? tsc_ff : 3'h0;
               nxt_ld = 1'b1;
            end else if (scene_diff) begin
               // Same preset, other scene: only the scene moves
               nxt_sl = 1'b1;
               nxt_csc = tsc_ff;
               nxt_dr = scene_edit_discard;
            end
         end
         default: nxt_st = MPCR_PC_IDLE;
      endcase
      // Edits clear only on a load or a discarding scene switch
      nxt_ep = edit_made || (ep_ff && !(pl_ff || dr_ff));
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_ff <= MPCR_PC_IDLE;
         num_ff <= 9'h000;
         tgt_ff <= 9'h000;
         tsc_ff <= 3'h0;
         tsv_ff <= 1'b0;
         cur_ff <= 9'h000;
         csc_ff <= 3'h0;
         ld_ff <= 1'b0;
         pl_ff <= 1'b0;
         sl_ff <= 1'b0;
         dr_ff <= 1'b0;
         ep_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         num_ff <= nxt_num;
         tgt_ff <= nxt_tgt;
         tsc_ff <= nxt_tsc;
         tsv_ff <= nxt_tsv;
         cur_ff <= nxt_cur;
         csc_ff <= nxt_csc;
         ld_ff <= nxt_ld;
         pl_ff <= nxt_pl;
         sl_ff <= nxt_sl;
         dr_ff <= nxt_dr;
         ep_ff <= nxt_ep;
      end
   end
   assign preset_load = pl_ff;
   assign scene_load = sl_ff;
   assign load_preset = cur_ff;
   assign load_scene = csc_ff;
   assign scene_edits_drop = dr_ff;
   assign edits_pending = ep_ff;
   assign display_preset = {1'b0, cur_ff}
      + {9'h000, display_numbering_base};

   // External controller values
   for (g = 0; g < `MPCR_EXT_N; g++) begin : g_ext
      logic rc_ff, nxt_rc;
      logic [6:0] ev_ff, nxt_ev;
      always_comb begin
         nxt_rc = rc_ff;
         nxt_ev = ev_ff;
         if (ext_wr_en && ext_wr_idx == 4'(g)) begin
            nxt_rc = 1'b1;
            nxt_ev = ext_wr_val;
         end
      end
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            rc_ff <= 1'b0;
            ev_ff <= `MPCR_EXT_ZERO;
         end else begin
            rc_ff <= nxt_rc;
            ev_ff <= nxt_ev;
         end
      end
      assign ext_value[7*g +: 7] = rc_ff ? ev_ff : (ext_default_full[g]
         ? `MPCR_EXT_FULL : `MPCR_EXT_ZERO);
   end

   chk_chan_filter: assert property ($rose(pend[0]) |-> $past(any_channel)
      || $past(g_parse[0].st_ff[3:0]) == $past(rx_channel))
      else $error("program change taken on a foreign channel");
   chk_pc_enable: assert property ($rose(pend[0]) |-> $past(pc_enable))
      else $error("program change taken while disabled");
   chk_offset_add: assert property (st_ff == MPCR_PC_IDLE && pend[0]
      |=> num_ff == {2'b00, $past(pnum[6:0])} + {1'b0, $past(pc_bank_add)})
      else $error("bank value not added");
   chk_remap_path: assert property (st_ff == MPCR_PC_LOOK && pc_remap_select
      && num_ff < `MPCR_MAP_LIMIT ##1 st_ff == MPCR_PC_ISSUE
      && !(same && repeat_pc_suppress) |=> preset_load && scene_load)
      else $error("remapped change did not load preset and scene");
   chk_direct_load: assert property (st_ff == MPCR_PC_LOOK && !pc_remap_select
      ##1 !(same && repeat_pc_suppress) |=> load_preset == $past(num_ff, 2))
      else $error("direct load preset mismatch");
   chk_repeat_drop: assert property (st_ff == MPCR_PC_ISSUE && same
      && repeat_pc_suppress |=> !preset_load ##1 !preset_load)
      else $error("repeated program change not dropped");
   chk_repeat_load: assert property (st_ff == MPCR_PC_ISSUE
      && !repeat_pc_suppress |=> preset_load ##1 !edits_pending || $past(edit_made))
      else $error("reload did not clear edits");
   chk_update_gate: assert property (fw_update |-> !fgnt[0] && !fgnt[1]
      && !fgnt[2] && !(acc[2] && need_c[2]) && !ugnt[0] && !ugnt[1])
      else $error("forwarding active during update");
   chk_live_none: assert property (live_status_msg_select == MPCR_LIVE_NONE
      && int_valid && int_kind != MPCR_KIND_OTHER |-> int_ready && !fgi)
      else $error("real-time message not suppressed");
   chk_scene_keep: assert property (scene_load && !preset_load
      && !scene_edits_drop && edits_pending |=> edits_pending)
      else $error("scene switch lost edits");
   chk_ext_default: assert property (!g_ext[2].rc_ff && ext_default_full[2]
      |-> ext_value[20:14] == `MPCR_EXT_FULL)
      else $error("controller default not held");
endmodule // mpcr_router

/* mpcr_sink.sv */
// Far-side byte sink for one outbound port of the router.
// Assumes one clock; the testbench reads the captured queue by hierarchy.
`timescale 1ns/1ps
module mpcr_sink (
   input wire logic clk,
   input wire logic valid,
   input wire logic [7:0] data,
   input wire logic stall,
   output logic ready
);
   logic [7:0] got[$];
   // A stalled sink refuses, as a busy receiver would
   assign ready = !stall;
   always @(posedge clk) begin
      if (valid && ready) begin
         got.push_back(data);
      end
   end
endmodule // mpcr_sink

/* testbench.sv */
// Self-checking bench for the program change router.
// Assumes mpcr_pkg, mpcr_router and mpcr_sink are compiled first.
`timescale 1ns/1ps
`include "mpcr_defines.svh"
module testbench;
   import mpcr_pkg::*;
   logic clk, rst_b, any_channel, input_echo_merge, fw_update, pc_enable;
   logic pc_remap_select, repeat_pc_suppress, scene_edit_discard;
   logic display_numbering_base, host_bridge_forwarding, remap_wr_en;
   logic ser_in_valid, ser_in_ready, fc_in_valid, fc_in_ready;
   logic usb_in_valid, usb_in_ready, int_valid, int_ready;
   logic ser_out_valid, ser_out_ready, fc_out_valid, fc_out_ready;
   logic usb_out_valid, usb_out_ready, preset_load, scene_load;
   logic scene_edits_drop, edit_made, edits_pending, ext_wr_en;
   logic [3:0] rx_channel, ext_wr_idx, vin, rin;
   logic [7:0] pc_bank_add, ser_in_data, fc_in_data, usb_in_data, int_data;
   logic [7:0] ser_out_data, fc_out_data, usb_out_data, din;
   logic [6:0] remap_wr_from, ext_wr_val;
   logic [8:0] remap_target_preset, load_preset;
   logic [2:0] remap_target_scene, load_scene, stall;
   logic [23:0] sysex_mfr_id;
   logic [9:0] display_preset;
   logic [11:0] ext_default_full;
   logic [83:0] ext_value;
   mpcr_live_type live_status_msg_select;
   mpcr_kind_type int_kind;
   int fails, total_checks;
   assign {int_valid, usb_in_valid, fc_in_valid, ser_in_valid} = vin;
   assign rin = {int_ready, usb_in_ready, fc_in_ready, ser_in_ready};
   assign ser_in_data = din;
   assign fc_in_data = din;
   assign usb_in_data = din;
   assign int_data = din;
   mpcr_router dut (.*);
   mpcr_sink sk_ser (.clk(clk), .valid(ser_out_valid), .data(ser_out_data),
      .stall(stall[0]), .ready(ser_out_ready));
   mpcr_sink sk_fc (.clk(clk), .valid(fc_out_valid), .data(fc_out_data),
      .stall(stall[1]), .ready(fc_out_ready));
   mpcr_sink sk_usb (.clk(clk), .valid(usb_out_valid), .data(usb_out_data),
      .stall(stall[2]), .ready(usb_out_ready));
   task automatic check(input string n, input logic [47:0] s, e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   function automatic logic [47:0] cat(input logic [7:0] q[$]);
      logic [47:0] r;
      r = 48'(q.size()) << (8 * q.size());
      foreach (q[i]) r = r | (48'(q[i]) << (8 * (q.size() - 1 - i)));
      return r;
   endfunction
   // Source 0 serial, 1 foot controller, 2 USB, 3 internal
   task automatic put(input int s, input logic [7:0] b, output logic ok);
      @(posedge clk);
      #1;
      din = b;
      vin[s] = 1'b1;
      ok = 1'b0;
      for (int i = 0; i < 8 && !ok; i++) begin
         #4;
         ok = rin[s];
         @(posedge clk);
         #1;
      end
      vin = 4'h0;
      // Released line must not keep showing the old byte
      din = ~b;
   endtask
   task automatic flush;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic clr;
      sk_ser.got.delete();
      sk_fc.got.delete();
      sk_usb.got.delete();
   endtask
   task automatic edit;
      @(posedge clk);
      #1;
      edit_made = 1'b1;
      @(posedge clk);
      #1;
      edit_made = 1'b0;
   endtask
   task automatic map(input logic [6:0] f, input logic [8:0] p,
         input logic [2:0] sc);
      @(posedge clk);
      #1;
      {remap_wr_from, remap_target_preset, remap_target_scene} = {f, p, sc};
      remap_wr_en = 1'b1;
      @(posedge clk);
      #1;
      remap_wr_en = 1'b0;
   endtask
   task automatic ld(input logic [7:0] st, n, input logic pl, sl, dr,
         input logic [8:0] p, input logic [2:0] sc);
      logic ok, gpl, gsl, gdr;
      put(0, st, ok);
      put(0, n, ok);
      {gpl, gsl, gdr} = 3'h0;
      repeat (8) begin
         @(posedge clk);
         #1;
         gpl |= preset_load;
         gsl |= scene_load;
         gdr |= scene_edits_drop;
      end
      check("preset_load", gpl, pl);
      check("scene_load", gsl, sl);
      if (pl || sl) begin
         check("load_preset", load_preset, p);
         check("load_scene", load_scene, sc);
      end
      if (sl && !pl) begin
         check("scene_edits_drop", gdr, dr);
      end
   endtask
   task automatic t_ext;
      check("sysex id", sysex_mfr_id, `MPCR_SYSEX_ID);
      for (int e = 0; e < 12; e++) begin
         check("ext default", ext_value[7*e +: 7],
            ext_default_full[e] ? 7'h7F : 7'h00);
      end
      @(posedge clk);
      #1;
      {ext_wr_idx, ext_wr_val, ext_wr_en} = {4'h3, 7'h15, 1'b1};
      @(posedge clk);
      #1;
      ext_wr_en = 1'b0;
      @(posedge clk);
      #1;
      check("ext written", ext_value[27:21], 7'h15);
      check("ext neighbour", ext_value[34:28], 7'h7F);
      $display("t_ext done");
   endtask
   task automatic t_basic;
      ld(8'hC0, 8'h0F, 1, 0, 0, 9'h00F, 3'h0);
      display_numbering_base = 1'b1;
      #1;
      check("display_preset", display_preset, 10'h010);
      edit;
      check("edits_pending", edits_pending, 1'b1);
      ld(8'hC0, 8'h0F, 1, 0, 0, 9'h00F, 3'h0);
      check("edits_pending", edits_pending, 1'b0);
      repeat_pc_suppress = 1'b1;
      edit;
      ld(8'hC0, 8'h0F, 0, 0, 0, 9'h00F, 3'h0);
      check("edits_pending", edits_pending, 1'b1);
      {display_numbering_base, repeat_pc_suppress} = 2'h0;
      $display("t_basic done");
   endtask
   task automatic t_filter;
      rx_channel = 4'h2;
      ld(8'hC0, 8'h14, 0, 0, 0, 9'h000, 3'h0);
      ld(8'hC2, 8'h14, 1, 0, 0, 9'h014, 3'h0);
      rx_channel = 4'hF;
      ld(8'hCF, 8'h17, 1, 0, 0, 9'h017, 3'h0);
      any_channel = 1'b1;
      ld(8'hC7, 8'h15, 1, 0, 0, 9'h015, 3'h0);
      pc_enable = 1'b0;
      ld(8'hC2, 8'h16, 0, 0, 0, 9'h000, 3'h0);
      check("load_preset kept", load_preset, 9'h015);
      {pc_enable, any_channel, rx_channel} = 6'h20;
      $display("t_filter done");
   endtask
   task automatic t_bank;
      pc_bank_add = 8'hFF;
      ld(8'hC0, 8'h7F, 1, 0, 0, 9'h17E, 3'h0);
      pc_bank_add = 8'h0A;
      map(7'h19, 9'h007, 3'h3);
      pc_remap_select = 1'b1;
      ld(8'hC0, 8'h0F, 1, 1, 0, 9'h007, 3'h3);
      ld(8'hC0, 8'h7F, 1, 0, 0, 9'h089, 3'h0);
      pc_bank_add = 8'h00;
      $display("t_bank done");
   endtask
   task automatic t_remap;
      map(7'h0F, 9'h17F, 3'h7);
      ld(8'hC0, 8'h0F, 1, 1, 0, 9'h17F, 3'h7);
      {scene_edit_discard, repeat_pc_suppress} = 2'h3;
      map(7'h10, 9'h17F, 3'h1);
      edit;
      ld(8'hC0, 8'h10, 0, 1, 1, 9'h17F, 3'h1);
      check("edits_pending", edits_pending, 1'b0);
      scene_edit_discard = 1'b0;
      edit;
      ld(8'hC0, 8'h0F, 0, 1, 0, 9'h17F, 3'h7);
      check("edits_pending", edits_pending, 1'b1);
      {pc_remap_select, repeat_pc_suppress} = 2'h0;
      $display("t_remap done");
   endtask
   task automatic t_route;
      logic ok;
      input_echo_merge = 1'b1;
      clr;
      put(0, 8'h90, ok);
      flush;
      check("echo ser", cat(sk_ser.got), 48'h0190);
      check("no bridge", cat(sk_usb.got), 48'h0);
      {input_echo_merge, host_bridge_forwarding} = 2'h1;
      clr;
      put(0, 8'h91, ok);
      put(1, 8'h92, ok);
      put(2, 8'h93, ok);
      flush;
      check("bridge usb", cat(sk_usb.got), 48'h029192);
      check("bridge ser", cat(sk_ser.got), 48'h0193);
      check("bridge fc", cat(sk_fc.got), 48'h0193);
      input_echo_merge = 1'b1;
      clr;
      put(3, 8'hF1, ok);
      put(0, 8'h94, ok);
      put(1, 8'h95, ok);
      put(2, 8'h96, ok);
      flush;
      check("merge", cat(sk_ser.got), 48'h04F1949596);
      fw_update = 1'b1;
      clr;
      put(0, 8'h97, ok);
      put(2, 8'h98, ok);
      flush;
      check("update ser", cat(sk_ser.got), 48'h0);
      check("update usb", cat(sk_usb.got), 48'h0);
      {fw_update, input_echo_merge, host_bridge_forwarding} = 3'h0;
      $display("t_route done");
   endtask
   task automatic t_live;
      logic ok;
      logic [47:0] e;
      int c;
      for (int m = 0; m < 4; m++) begin
         live_status_msg_select = mpcr_live_type'(m);
         clr;
         for (int k = 0; k < 3; k++) begin
            int_kind = mpcr_kind_type'(k);
            put(3, 8'h10 + 8'(k), ok);
         end
         flush;
         e = 48'h10;
         c = 1;
         if (m == 1 || m == 2) begin
            e = {e[39:0], 8'h11};
            c++;
         end
         if (m == 1 || m == 3) begin
            e = {e[39:0], 8'h12};
            c++;
         end
         e = e | (48'(c) << (8 * c));
         check("live status", cat(sk_ser.got), e);
      end
      live_status_msg_select = MPCR_LIVE_ALL;
      $display("t_live done");
   endtask
   task automatic t_fifo;
      logic ok;
      int acc;
      input_echo_merge = 1'b1;
      stall = 3'h1;
      clr;
      acc = 0;
      // Note-off status first so the data bytes never form program changes
      for (int i = 0; i < 20; i++) begin
         put(0, (i == 0) ? 8'h80 : 8'(i), ok);
         acc += ok;
      end
      check("fifo accepted", acc, `MPCR_FIFO_D);
      check("fifo head", ser_out_data, 8'h80);
      stall = 3'h0;
      repeat (24) @(posedge clk);
      #1;
      check("fifo drained", sk_ser.got.size(), `MPCR_FIFO_D);
      check("fifo last", sk_ser.got[15], 8'h0F);
      check("fifo empty", ser_out_valid, 1'b0);
      input_echo_merge = 1'b0;
      $display("t_fifo done");
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst_b, any_channel, input_echo_merge, fw_update, pc_remap_select,
         repeat_pc_suppress, scene_edit_discard, display_numbering_base,
         host_bridge_forwarding, remap_wr_en, edit_made, ext_wr_en} = '0;
      {vin, din, stall, pc_bank_add, rx_channel} = '0;
      {remap_wr_from, remap_target_preset, remap_target_scene} = '0;
      {ext_wr_idx, ext_wr_val} = '0;
      pc_enable = 1'b1;
      ext_default_full = 12'hA5C;
      live_status_msg_select = MPCR_LIVE_ALL;
      int_kind = MPCR_KIND_OTHER;
      repeat (8) @(posedge clk);
      #1;
      rst_b = 1'b1;
      t_ext;
      t_basic;
      t_filter;
      t_bank;
      t_remap;
      t_route;
      t_live;
      t_fifo;
      give_verdict;
   end
   // The whole sequence needs well under 3000 cycles
   initial begin
      #200000;
      fails++;
      give_verdict;
   end
endmodule // testbench
